// [hdl/osw_ctrl.sv]
// Purpose: oscillator control register, clock fail flag, switch request and interrupt
// Assumes: monitor fail pulse and switch done pulse come from the clock tree
// Notes:   read data valid one cycle after the read strobe
// Function
// - clock monitor failure sets the fail flag in bit 3; reads 0 otherwise.
// - software writing 1 to the fail flag acts as a failure and raises the trap.
// - writing 1 to bit 0 requests a switch to the new source select field; the code refuses a move from one pll source to the other.
// - switch request bit returns to 0 when the switch has completed.
// - control register writes take effect only after the unlock sequence.
// - bit 4 and bits 2 to 1 have no storage and read as zero.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module osw_ctrl (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire osw_pkg::osw_bus_t bus,
   input  wire logic             monitor_fail,
   input  wire logic             switch_done,
   output logic [15:0]           rdata,
   output logic                  fail_trap,
   output logic                  switch_start,
   output logic [2:0]            switch_target,
   output logic                  irq
);
   import osw_pkg::*;
   logic        open;
   logic        ctrl_wr;
   logic        clk_fail;
   logic        next_clk_fail;
   logic        sw_req;
   logic        next_sw_req;
   logic [2:0]  new_source_select;
   logic [2:0]  next_new_source_select;
   logic [2:0]  cur_src;
   logic [2:0]  next_cur_src;
   logic [1:0]  irq_status;
   logic [1:0]  next_irq_status;
   logic [1:0]  irq_enable;
   logic [1:0]  next_irq_enable;
   logic [15:0] next_rdata;
   logic        next_fail_trap;
   logic        next_switch_start;
   logic        next_irq;
   logic        soft_fail;
   logic        any_fail;

   ////////////////////////////////////////////////////////////////////////////
   osw_unlock u_unlock (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .key_wr   (bus.wr && bus.addr == ADDR_UNLOCK),
      .key_data (bus.wdata),
      .ctrl_wr  (bus.wr && bus.addr == ADDR_OSC_CTRL),
      .open     (open)
   );

   assign ctrl_wr = bus.wr && bus.addr == ADDR_OSC_CTRL && open;

   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction

   // plain register write decode, used only by the interrupt group below
   function automatic logic wr_at(input osw_bus_t b, input logic [3:0] a);
      wr_at = b.wr && (b.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // fail flag and trap
   always_comb begin
      soft_fail     = ctrl_wr && bus.wdata[BIT_CLK_FAIL];
      any_fail      = monitor_fail || soft_fail;
      next_clk_fail = clk_fail;
      // hardware set wins over a software clear in the same cycle
      if (ctrl_wr && !bus.wdata[BIT_CLK_FAIL]) begin
         next_clk_fail = 1'b0;
      end
      if (any_fail) begin
         next_clk_fail = 1'b1;
      end
      next_fail_trap = any_fail;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_fail  <= 1'b0;
         fail_trap <= 1'b0;
      end else begin
         clk_fail  <= next_clk_fail;
         fail_trap <= next_fail_trap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // switch request and current source
   always_comb begin
      next_new_source_select         = new_source_select;
      next_sw_req       = sw_req;
      next_switch_start = 1'b0;
      next_cur_src      = cur_src;
      if (ctrl_wr) begin
         next_new_source_select = bus.wdata[NEW_SOURCE_SELECT_LSB +: 3];
      end
      if (sw_req && switch_done) begin
         next_sw_req  = 1'b0;
         next_cur_src = new_source_select;
      end
      // a pll to pll request is dropped as done with no switch,
      // so a polling driver never hangs on a refused move
      if (ctrl_wr && bus.wdata[BIT_SWITCH_REQ] && !sw_req) begin
         if (is_pll(cur_src) && is_pll(bus.wdata[NEW_SOURCE_SELECT_LSB +: 3])
             && cur_src != bus.wdata[NEW_SOURCE_SELECT_LSB +: 3]) begin
            next_sw_req = 1'b0;
         end else begin
            next_sw_req       = 1'b1;
            next_switch_start = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sw_req        <= 1'b0;
         new_source_select          <= RESET_SRC;
         cur_src       <= RESET_SRC;
         switch_start  <= 1'b0;
         switch_target <= RESET_SRC;
      end else begin
         sw_req        <= next_sw_req;
         new_source_select          <= next_new_source_select;
         cur_src       <= next_cur_src;
         switch_start  <= next_switch_start;
         switch_target <= next_new_source_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, enable and line
   always_comb begin
      next_irq_enable = irq_enable;
      next_irq_status = irq_status;
      if (wr_at(bus, ADDR_IRQ_ENABLE)) begin
         next_irq_enable = bus.wdata[1:0];
      end
      if (wr_at(bus, ADDR_IRQ_CLEAR)) begin
         next_irq_status = irq_status & ~bus.wdata[1:0];
      end
      // events set after the clear so a set wins
      if (any_fail) begin
         next_irq_status = next_irq_status | IRQ_BIT_FAIL;
      end
      if (sw_req && switch_done) begin
         next_irq_status = next_irq_status | IRQ_BIT_DONE;
      end
      next_irq = |(next_irq_status & next_irq_enable);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_status <= 2'h0;
         irq_enable <= 2'h0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
         irq        <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe and zero otherwise
   always_comb begin
      next_rdata = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_OSC_CTRL: begin
               // bits 4 and 2..1 have no storage
               next_rdata[BIT_SWITCH_REQ]  = sw_req;
               next_rdata[BIT_CLK_FAIL]    = clk_fail;
               next_rdata[NEW_SOURCE_SELECT_LSB +: 3]   = new_source_select;
            end
            ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
            ADDR_IRQ_ENABLE: next_rdata[1:0] = irq_enable;
            ADDR_CUR_SRC:    next_rdata[2:0] = cur_src;
            default:         next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end
endmodule

// [hdl/osw_pkg.sv]
// Purpose: shared constants and types for the oscillator switch and fail flag block
// Assumes: 16-bit register port, one clock
// Notes:   offsets are word indices on the plain register port
package osw_pkg;
   localparam logic [3:0]  ADDR_OSC_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_UNLOCK     = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'h3;
   localparam logic [3:0]  ADDR_IRQ_CLEAR  = 4'h4;
   localparam logic [3:0]  ADDR_CUR_SRC    = 4'h5;
   localparam int          BIT_SWITCH_REQ  = 0;
   localparam int          BIT_CLK_FAIL    = 3;
   localparam int          NEW_SOURCE_SELECT_LSB        = 8;
   localparam logic [15:0] KEY_FIRST       = 16'h0055;
   localparam logic [15:0] KEY_SECOND      = 16'h00AA;
   localparam logic [2:0]  WINDOW_CYCLES   = 3'h4;
   localparam logic [2:0]  SRC_FRC         = 3'h0;
   localparam logic [2:0]  SRC_FRC_PLL     = 3'h1;
   localparam logic [2:0]  SRC_PRI_PLL     = 3'h3;
   localparam logic [2:0]  RESET_SRC       = 3'h0;
   localparam logic [1:0]  IRQ_BIT_FAIL    = 2'h1;
   localparam logic [1:0]  IRQ_BIT_DONE    = 2'h2;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } osw_bus_t;

   typedef enum logic [2:0] {
      UNL_IDLE  = 3'b001,
      UNL_KEY1  = 3'b010,
      UNL_OPEN  = 3'b100
   } osw_unlock_t;
endpackage

// [hdl/osw_unlock.sv]
// Purpose: key sequence gate for writes to the oscillator control register
// Assumes: keys written to the unlock address on consecutive writes
// Notes:   window closes on timeout, on any key write, or on the first control write
`timescale 1ns/1ps
module osw_unlock (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic          key_wr,
   input  wire logic [15:0]   key_data,
   input  wire logic          ctrl_wr,
   output logic               open
);
   import osw_pkg::*;
   osw_unlock_t state;
   osw_unlock_t next_state;
   logic [2:0]  timer;
   logic [2:0]  next_timer;

   always_comb begin
      next_state = state;
      next_timer = timer;
      unique case (state)
         UNL_IDLE: begin
            if (key_wr && key_data == KEY_FIRST) begin
               next_state = UNL_KEY1;
            end
         end
         UNL_KEY1: begin
            // any other unlock write or a control write aborts the sequence
            if (key_wr && key_data == KEY_SECOND) begin
               next_state = UNL_OPEN;
               next_timer = WINDOW_CYCLES;
            end else if (key_wr || ctrl_wr) begin
               next_state = UNL_IDLE;
            end
         end
         UNL_OPEN: begin
            next_timer = timer - 3'h1;
            if (ctrl_wr || timer == 3'h1 || key_wr) begin
               next_state = UNL_IDLE;
            end
         end
         default: next_state = UNL_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= UNL_IDLE;
         timer <= 3'h0;
      end else begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   assign open = (state == UNL_OPEN);
endmodule

// [verification/osw_ctrl_asserts.sv]
// Purpose: port assertions for osw_ctrl
// Assumes: key pair and short write window from osw_pkg
// Notes:   bound into every osw_ctrl
`timescale 1ns/1ps
module osw_ctrl_asserts (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire osw_pkg::osw_bus_t bus,
   input wire logic              monitor_fail,
   input wire logic [15:0]       rdata,
   input wire logic              fail_trap,
   input wire logic              switch_start,
   input wire logic [2:0]        switch_target
);
   import osw_pkg::*;
   logic       key_ok;
   logic       sw_fail;
   logic       sw_req;
   logic       rd_ctl;
   logic [2:0] new_src;
   assign key_ok  = bus.wr && bus.addr == ADDR_UNLOCK && bus.wdata == KEY_SECOND;
   assign sw_fail = bus.wr && bus.addr == ADDR_OSC_CTRL && bus.wdata[BIT_CLK_FAIL];
   assign sw_req  = bus.wr && bus.addr == ADDR_OSC_CTRL && bus.wdata[BIT_SWITCH_REQ];
   assign rd_ctl  = bus.rd && bus.addr == ADDR_OSC_CTRL;
   assign new_src = bus.wdata[NEW_SOURCE_SELECT_LSB +: 3];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_hw_fail_trap: assert property (monitor_fail |=> fail_trap) else $error("trap missing");
   a_trap_has_cause: assert property (fail_trap |-> $past(monitor_fail) || $past(sw_fail))
      else $error("trap without cause");
   // key accepted two to five edges before the trap, window of four
   a_trap_unlocked: assert property (fail_trap && !$past(monitor_fail)
      |-> $past(key_ok, 2) || $past(key_ok, 3) || $past(key_ok, 4) || $past(key_ok, 5)) else $error("locked");
   a_start_cause: assert property (switch_start |-> $past(sw_req)) else $error("start without req");
   a_start_target: assert property (switch_start |-> switch_target == $past(new_src))
      else $error("bad target");
   a_start_single: assert property (switch_start |=> !switch_start) else $error("start twice");
   a_idle_rdata: assert property (!$past(bus.rd) |-> rdata == 16'h0000) else $error("rdata not 0");
   a_rsvd_zero: assert property ($past(rd_ctl) |-> (rdata & 16'hF8F6) == 16'h0000)
      else $error("reserved bits set");
endmodule
bind osw_ctrl osw_ctrl_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .bus(bus), .monitor_fail(monitor_fail),
   .rdata(rdata), .fail_trap(fail_trap), .switch_start(switch_start), .switch_target(switch_target));

// [verification/oscillator_switch_and_fail_flag_bench.sv]
// Purpose: self-checking bench for osw_ctrl
// Assumes: 20 MHz clock, sync reset held 4 cycles
// Notes:   table walks legal and refused source switches
`timescale 1ns/1ps
module oscillator_switch_and_fail_flag_bench;
   import osw_pkg::*;
   typedef struct packed {logic start; logic [2:0] src;} osw_row_t;
   logic          ref_clk;
   logic          rst;
   osw_bus_t      bus;
   logic          monitor_fail;
   logic          switch_done;
   logic [15:0]   rdata;
   logic          fail_trap;
   logic          switch_start;
   logic [2:0]    switch_target;
   logic          irq;
   int            n_mismatch;
   int            num_checks;
   logic [2:0]    cur;
   // start expected, source; pll to pll rows are refused
   osw_row_t      rows [8] = '{4'h9, 4'h3, 4'h8, 4'hB, 4'h1, 4'h8, 4'hF, 4'hA};
   osw_ctrl dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .monitor_fail(monitor_fail), .switch_done(switch_done),
      .rdata(rdata), .fail_trap(fail_trap), .switch_start(switch_start), .switch_target(switch_target), .irq(irq));
   task op(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
      @(posedge ref_clk);
      bus <= '{a, d, w, r};
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      op(a, 16'h0000, 1'b0, 1'b1);
      op(4'h0, 16'h0000, 1'b0, 1'b0);
      #1 chk("rdata", e, rdata);
   endtask
   task ctl(input logic [15:0] d, input logic unl);
      if (unl) begin
         op(ADDR_UNLOCK, KEY_FIRST, 1'b1, 1'b0);
         op(ADDR_UNLOCK, KEY_SECOND, 1'b1, 1'b0);
      end
      op(ADDR_OSC_CTRL, d, 1'b1, 1'b0);
      op(4'h0, 16'h0000, 1'b0, 1'b0);
      #1;
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // whole run is under 150 cycles
   initial begin
      #(50 * 3000);
      n_mismatch++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      bus = '0;
      monitor_fail = 1'b0;
      switch_done = 1'b0;
      cur = RESET_SRC;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADDR_OSC_CTRL, 16'h0000);
      rd(ADDR_CUR_SRC, {13'h0, RESET_SRC});
      foreach (rows[i]) begin
         ctl({5'h00, rows[i].src, 8'h01}, 1'b1);
         chk("switch_start", {15'h0, rows[i].start}, {15'h0, switch_start});
         chk("switch_target", {13'h0, rows[i].src}, {13'h0, switch_target});
         rd(ADDR_OSC_CTRL, {5'h00, rows[i].src, 7'h00, rows[i].start});
         @(posedge ref_clk) switch_done <= 1'b1;
         @(posedge ref_clk) switch_done <= 1'b0;
         if (rows[i].start)
            cur = rows[i].src;
         rd(ADDR_OSC_CTRL, {5'h00, rows[i].src, 8'h00});
         rd(ADDR_CUR_SRC, {13'h0, cur});
      end
      ctl(16'h0008, 1'b0);
      chk("fail_trap", 16'h0000, {15'h0, fail_trap});
      rd(ADDR_OSC_CTRL, 16'h0200);
      op(ADDR_IRQ_ENABLE, {14'h0, IRQ_BIT_FAIL}, 1'b1, 1'b0);
      ctl(16'h0208, 1'b1);
      chk("fail_trap", 16'h0001, {15'h0, fail_trap});
      chk("irq", 16'h0001, {15'h0, irq});
      rd(ADDR_OSC_CTRL, 16'h0208);
      ctl(16'h0216, 1'b1);
      rd(ADDR_OSC_CTRL, 16'h0200);
      op(ADDR_IRQ_CLEAR, {14'h0, IRQ_BIT_FAIL}, 1'b1, 1'b0);
      op(4'h0, 16'h0000, 1'b0, 1'b0);
      #1 chk("irq", 16'h0000, {15'h0, irq});
      @(posedge ref_clk) monitor_fail <= 1'b1;
      @(posedge ref_clk) monitor_fail <= 1'b0;
      #1 chk("fail_trap", 16'h0001, {15'h0, fail_trap});
      chk("irq", 16'h0001, {15'h0, irq});
      rd(ADDR_OSC_CTRL, 16'h0208);
      op(ADDR_IRQ_ENABLE, 16'h0000, 1'b1, 1'b0);
      op(4'h0, 16'h0000, 1'b0, 1'b0);
      #1 chk("irq", 16'h0000, {15'h0, irq});
      rd(ADDR_IRQ_STATUS, {14'h0, IRQ_BIT_FAIL | IRQ_BIT_DONE});
      rd(4'hF, 16'h0000);
      conclude();
   end
endmodule
